// File: src/ddl_pkg.sv
// Shared constants and types for the dual converter serial loader
package ddl_pkg;

  localparam int unsigned DATA_W    = 12;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned CNT_W     = 5;
  localparam int unsigned CHAN_POS  = 12;
  localparam int unsigned ADDR_W    = 5;

  localparam logic [CNT_W-1:0] LAST_BIT_CNT = 5'h0F;
  localparam logic [CNT_W-1:0] FULL_CNT     = 5'h10;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 5'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 5'h04;
  localparam logic [ADDR_W-1:0] LATCH_A_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] LATCH_B_OFS = 5'h0C;
  localparam logic [ADDR_W-1:0] INPUT_A_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] INPUT_B_OFS = 5'h14;

  // Control field positions (write-one pulses)
  localparam int unsigned CTRL_LOAD_POS  = 0;
  localparam int unsigned CTRL_CLEAR_POS = 1;

  // Status field positions
  localparam int unsigned ST_AUTO_POS   = 0;
  localparam int unsigned ST_FMT_POS    = 1;
  localparam int unsigned ST_LOAD_POS   = 2;
  localparam int unsigned ST_FRAME_POS  = 3;
  localparam int unsigned ST_CNT_LO     = 8;
  localparam int unsigned WORD_CNT_W    = 8;

  // Latch codes: converter core always sees offset binary
  localparam logic [DATA_W-1:0] CLEAR_CODE_BIN  = 12'h000;
  localparam logic [DATA_W-1:0] CLEAR_CODE_TWOS = 12'h800;
  localparam logic [DATA_W-1:0] MSB_FLIP        = 12'h800;

  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic              chan_b;
    logic [DATA_W-1:0] data;
  } ddl_word_s;

  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
  } ddl_pair_s;

endpackage : ddl_pkg

// File: src/ddl_serial_loader.sv
// Serial loader: link shift register, channel input/latch registers, Avalon-MM slave
`timescale 1ns/1ps

module ddl_serial_loader
  import ddl_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                serial_clk,
  input  wire logic                frame_sync_n,
  input  wire logic                serial_data_in,
  input  wire logic                latch_load_n,
  input  wire logic                clear_all_n,
  input  wire logic                format_select,
  output logic      [DATA_W-1:0]   output_a,
  output logic      [DATA_W-1:0]   output_b
);

  // Link domain, clocked on the falling serial clock edge
  logic [CNT_W-1:0]  bit_cnt_reg;
  logic [CNT_W-1:0]  bit_cnt_next;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;
  logic              done_tgl_reg;
  logic              done_tgl_next;

  always_comb
  begin
    bit_cnt_next  = bit_cnt_reg;
    shift_next    = shift_reg;
    word_next     = word_reg;
    done_tgl_next = done_tgl_reg;
    if (bit_cnt_reg != FULL_CNT)
    begin
      shift_next   = {shift_reg[WORD_W-2:0], serial_data_in};
      bit_cnt_next = bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == LAST_BIT_CNT)
      begin
        word_next     = {shift_reg[WORD_W-2:0], serial_data_in};
        done_tgl_next = ~done_tgl_reg;
      end
    end
  end

  // Frame strobe high holds the counter at zero, so a low frame starts clean
  // even if the link clock stood still in between
  always_ff @(negedge serial_clk or posedge frame_sync_n or posedge reset)
  begin
    if (reset || frame_sync_n)
      bit_cnt_reg <= '0;
    else
      bit_cnt_reg <= bit_cnt_next;
  end

  always_ff @(negedge serial_clk or posedge reset)
  begin
    if (reset)
    begin
      shift_reg    <= '0;
      word_reg     <= '0;
      done_tgl_reg <= 1'b0;
    end
    else
    begin
      shift_reg    <= shift_next;
      word_reg     <= word_next;
      done_tgl_reg <= done_tgl_next;
    end
  end

  // System domain synchronisers
  logic [1:0] tgl_sync_reg;
  logic [1:0] frame_sync_reg;
  logic [1:0] load_sync_reg;
  logic [1:0] clear_sync_reg;
  logic [1:0] fmt_sync_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tgl_sync_reg   <= 2'h0;
      frame_sync_reg <= 2'h3;
      load_sync_reg  <= 2'h3;
      clear_sync_reg <= 2'h3;
      fmt_sync_reg   <= 2'h0;
    end
    else
    begin
      tgl_sync_reg   <= {tgl_sync_reg[0], done_tgl_reg};
      frame_sync_reg <= {frame_sync_reg[0], frame_sync_n};
      load_sync_reg  <= {load_sync_reg[0], latch_load_n};
      clear_sync_reg <= {clear_sync_reg[0], clear_all_n};
      fmt_sync_reg   <= {fmt_sync_reg[0], format_select};
    end
  end

  // Word register is stable for at least fifteen link clocks after the
  // toggle, far longer than the toggle takes to cross, so it is read directly
  function automatic logic [DATA_W-1:0] to_core(input logic [DATA_W-1:0] d,
                                                input logic twos);
    to_core = twos ? (d ^ MSB_FLIP) : d;
  endfunction : to_core

  function automatic logic [DATA_W-1:0] clear_code(input logic twos);
    clear_code = twos ? CLEAR_CODE_TWOS : CLEAR_CODE_BIN;
  endfunction : clear_code

  logic                  tgl_seen_reg;
  logic                  tgl_seen_next;
  logic                  frame_prev_reg;
  logic                  frame_prev_next;
  logic                  load_prev_reg;
  logic                  load_prev_next;
  logic                  auto_mode_reg;
  logic                  auto_mode_next;
  ddl_pair_s             input_reg;
  ddl_pair_s             input_next;
  ddl_pair_s             latch_reg;
  ddl_pair_s             latch_next;
  logic [WORD_CNT_W-1:0] word_cnt_reg;
  logic [WORD_CNT_W-1:0] word_cnt_next;
  logic                  ack_reg;
  logic                  ack_next;
  logic [31:0]           rdata_reg;
  logic [31:0]           rdata_next;

  ddl_word_s rx_word;
  logic      twos;
  logic      word_arrived;
  logic      load_fall;
  logic      wr_take;
  logic      sw_load;
  logic      sw_clear;

  always_comb
  begin
    rx_word.chan_b = word_reg[CHAN_POS];
    rx_word.data   = word_reg[DATA_W-1:0];
    twos           = fmt_sync_reg[1];
    word_arrived   = tgl_sync_reg[1] != tgl_seen_reg;
    load_fall      = load_prev_reg && !load_sync_reg[1];
    wr_take        = avs_write && ack_reg && (avs_address == CTRL_OFS)
                     && avs_byteenable[0];
    sw_load        = wr_take && avs_writedata[CTRL_LOAD_POS];
    sw_clear       = wr_take && avs_writedata[CTRL_CLEAR_POS];
  end

  always_comb
  begin
    tgl_seen_next   = tgl_sync_reg[1];
    frame_prev_next = frame_sync_reg[1];
    load_prev_next  = load_sync_reg[1];
    auto_mode_next  = auto_mode_reg;
    input_next      = input_reg;
    latch_next      = latch_reg;
    word_cnt_next   = word_cnt_reg;
    if (frame_prev_reg && !frame_sync_reg[1])
      auto_mode_next = !load_sync_reg[1];
    if (word_arrived)
    begin
      word_cnt_next = word_cnt_reg + 8'h01;
      if (rx_word.chan_b)
        input_next.b = to_core(rx_word.data, twos);
      else
        input_next.a = to_core(rx_word.data, twos);
      if (auto_mode_reg)
      begin
        if (rx_word.chan_b)
          latch_next.b = to_core(rx_word.data, twos);
        else
          latch_next.a = to_core(rx_word.data, twos);
      end
    end
    if (load_fall || sw_load)
      latch_next = input_next;
    // Clear is level sensitive and overrides any load in the same cycle
    if (!clear_sync_reg[1] || sw_clear)
    begin
      latch_next.a = clear_code(twos);
      latch_next.b = clear_code(twos);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tgl_seen_reg   <= 1'b0;
      frame_prev_reg <= 1'b1;
      load_prev_reg  <= 1'b1;
      auto_mode_reg  <= 1'b0;
      input_reg      <= '0;
      latch_reg      <= '0;
      word_cnt_reg   <= '0;
    end
    else
    begin
      tgl_seen_reg   <= tgl_seen_next;
      frame_prev_reg <= frame_prev_next;
      load_prev_reg  <= load_prev_next;
      auto_mode_reg  <= auto_mode_next;
      input_reg      <= input_next;
      latch_reg      <= latch_next;
      word_cnt_reg   <= word_cnt_next;
    end
  end

  // Avalon-MM slave: one wait cycle, read data registered during it
  always_comb
  begin
    ack_next   = (avs_read || avs_write) && !ack_reg;
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg)
    begin
      if (avs_address == STATUS_OFS)
      begin
        rdata_next = READ_ZERO;
        rdata_next[ST_AUTO_POS]  = auto_mode_reg;
        rdata_next[ST_FMT_POS]   = twos;
        rdata_next[ST_LOAD_POS]  = load_sync_reg[1];
        rdata_next[ST_FRAME_POS] = !frame_sync_reg[1];
        rdata_next[ST_CNT_LO +: WORD_CNT_W] = word_cnt_reg;
      end
      else if (avs_address == LATCH_A_OFS)
        rdata_next = {20'h00000, latch_reg.a};
      else if (avs_address == LATCH_B_OFS)
        rdata_next = {20'h00000, latch_reg.b};
      else if (avs_address == INPUT_A_OFS)
        rdata_next = {20'h00000, input_reg.a};
      else if (avs_address == INPUT_B_OFS)
        rdata_next = {20'h00000, input_reg.b};
      else
        rdata_next = READ_ZERO;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata    = rdata_reg;
  assign output_a        = latch_reg.a;
  assign output_b        = latch_reg.b;

endmodule : ddl_serial_loader

// File: tb/ddl_chk.sv
// Bus and latch property checker for the serial loader
`timescale 1ns/1ps
module ddl_chk
  import ddl_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              frame_sync_n,
  input wire logic              latch_load_n,
  input wire logic              clear_all_n,
  input wire logic              format_select,
  input wire logic [DATA_W-1:0] output_a,
  input wire logic [DATA_W-1:0] output_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire rd_done = avs_read && !avs_waitrequest;
  chk_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("request answered without a wait cycle");
  chk_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait lasted more than one cycle");
  chk_wait_idle: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("wait raised while idle");
  chk_rd_ctrl: assert property (rd_done && avs_address == CTRL_OFS |-> avs_readdata == READ_ZERO)
    else $error("control read not zero");
  chk_rd_unmap: assert property (rd_done && avs_address == 5'h18 |-> avs_readdata == READ_ZERO)
    else $error("unmapped read not zero");
  chk_rd_upper: assert property (rd_done |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_clr_a: assert property (!clear_all_n [*5] |->
    output_a == (format_select ? CLEAR_CODE_TWOS : CLEAR_CODE_BIN)) else $error("clear A");
  chk_clr_b: assert property (!clear_all_n [*5] |->
    output_b == (format_select ? CLEAR_CODE_TWOS : CLEAR_CODE_BIN)) else $error("clear B");
  chk_out_quiet: assert property ((clear_all_n && latch_load_n && frame_sync_n &&
    !avs_write) [*8] |-> $stable({output_a, output_b})) else $error("outputs moved idle");
endmodule : ddl_chk

bind ddl_serial_loader ddl_chk chk_i (.*);

// File: tb/ddl_host.sv
// Behavioural host driving the three-wire link
`timescale 1ns/1ps
module ddl_host
(
  output logic serial_clk,
  output logic frame_sync_n,
  output logic serial_data_in
);
  initial
  begin
    serial_clk = 1'b0;
    frame_sync_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Clock parks low between frames; released data shows its inverse
  task automatic send(input logic [15:0] word, input int extra);
    int i;
    #3;
    frame_sync_n = 1'b0;
    #40;
    for (i = 15; i >= -extra; i--)
    begin
      serial_data_in = (i >= 0) ? word[i] : ~serial_data_in;
      serial_clk = 1'b1;
      #62.5;
      serial_clk = 1'b0;
      #62.5;
    end
    frame_sync_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #300;
  endtask : send
endmodule : ddl_host

// File: tb/tb.sv
// Self-checking bench for the serial loader
`timescale 1ns/1ps
module tb
  import ddl_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              serial_clk;
  logic              frame_sync_n;
  logic              serial_data_in;
  logic              latch_load_n = 1'b0;
  logic              clear_all_n = 1'b1;
  logic              format_select = 1'b0;
  logic [DATA_W-1:0] output_a;
  logic [DATA_W-1:0] output_b;
  logic [31:0]       rdata;
  int                errors = 0;
  int                checks = 0;
  // Format, word, expected A, expected B
  logic [40:0]       rows [4] = '{{1'h0, 16'h0ABC, 12'hABC, 12'h000},
    {1'h0, 16'hF123, 12'hABC, 12'h123}, {1'h1, 16'h0800, 12'h000, 12'h123},
    {1'h1, 16'h1000, 12'h000, 12'h800}};

  always #5 sys_clk = ~sys_clk;

  ddl_serial_loader uut (.avs_byteenable(4'hF), .*);
  ddl_host host (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] adr, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #200000;
    errors++;
    wrap_up;
  end

  initial
  begin
    cyc(10);
    reset <= 1'b0;
    cyc(3);
    check(output_a, 12'h000);
    check(output_b, 12'h000);
    for (int r = 0; r < 4; r++)
    begin
      format_select <= rows[r][40];
      cyc(5);
      host.send(rows[r][39:24], 0);
      cyc(4);
      check(output_a, rows[r][23:12]);
      check(output_b, rows[r][11:0]);
      $display("row %0d done", r);
    end
    // Strobed frames; the second carries surplus clocks that must be locked out
    format_select <= 1'b0;
    latch_load_n <= 1'b1;
    cyc(5);
    host.send(16'h0555, 0);
    host.send(16'h1777, 4);
    cyc(4);
    check(output_b, 12'h800);
    latch_load_n <= 1'b0;
    cyc(6);
    check(output_a, 12'h555);
    check(output_b, 12'h777);
    $display("strobe test done");
    clear_all_n <= 1'b0;
    cyc(6);
    check(output_a, 12'h000);
    clear_all_n <= 1'b1;
    format_select <= 1'b1;
    cyc(5);
    clear_all_n <= 1'b0;
    cyc(6);
    check(output_b, 12'h800);
    clear_all_n <= 1'b1;
    cyc(5);
    $display("clear test done");
    bus(1'b0, 5'h18, 32'h0);
    check(rdata, READ_ZERO);
    bus(1'b0, CTRL_OFS, 32'h0);
    check(rdata, READ_ZERO);
    bus(1'b0, STATUS_OFS, 32'h0);
    check(rdata[ST_FMT_POS], 1'b1);
    check(rdata[ST_AUTO_POS], 1'b0);
    check(rdata[ST_CNT_LO +: WORD_CNT_W], 8'h06);
    bus(1'b1, CTRL_OFS, 32'h1);
    cyc(4);
    check(output_a, 12'h555);
    bus(1'b1, LATCH_A_OFS, 32'hFFF);
    bus(1'b0, LATCH_A_OFS, 32'h0);
    check(rdata, 32'h555);
    $display("bus test done");
    wrap_up;
  end
endmodule : tb
